// ---- verilog/bsac_regs.sv ----
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module bsac_regs
(
    // Clock and reset.
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    // APB slave.
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [7:0]               paddr,
    input  wire logic [31:0]              pwdata,
    output logic                          pready,
    output logic                          pslverr,
    output logic [31:0]                   prdata,
    // Sensor readings and raw CSI-2 events.
    input  wire bsac_pkg::bsac_sense_s    sense_codes,
    input  wire logic                     missing_frame_valid_event,
    input  wire logic                     phy_sync_error_event,
    // Self-test and injection controls.
    output logic                          parity_error_strobe,
    output logic                          self_test_mode,
    output logic                          remote_self_test_enable,
    output bsac_pkg::bsac_clk_sel_e       self_test_clock_select,
    // Sensor controls.
    output logic [6:0]                    voltage_gain_divisor,
    output logic                          gain_setting_enable,
    output logic                          sensors_enabled,
    output logic                          volt0_sense_enable,
    output logic                          volt1_sense_enable,
    // Alarms.
    output bsac_pkg::bsac_alarm_s         sensor_alarms,
    output logic                          missing_frame_valid_alarm,
    output logic                          phy_sync_error_alarm
);
    import bsac_pkg::*;

    //--------------------------------------------------------------------------
    // Register storage and bus decode
    //--------------------------------------------------------------------------
    logic [7:0] regs_q [NUM_REGS];   // Register bank, index from the first.
    logic [5:0] idx;                 // Word index from the byte address.
    logic       hit;                 // Address maps onto a register.
    logic [3:0] slot;                // Position in the bank.
    logic       err_q;               // Error answer latched in setup.
    logic       wr_en;               // Write takes effect this edge.
    logic       inject_q;            // Inject bit, self-clearing.
    logic [6:0] remaining_q;         // Errors still to be injected.
    logic       strobe_q;            // Registered injection strobe.
    logic       local_prev_q;        // Self-test enable one cycle ago.
    logic       start;               // Injection sequence starts.
    logic       entering;            // Self-test mode is being entered.
    bsac_alarm_s alarm_q;            // Registered threshold alarms.
    logic       no_fv_alarm_q;       // Registered gated frame alarm.
    logic       sync_alarm_q;        // Registered gated sync alarm.

    assign idx  = paddr[7:2];
    assign hit  = (paddr[1:0] == 2'b00) && (idx >= IDX_RESERVED_12)
                  && (idx <= IDX_CSI_ALARM_EN);
    assign slot = 4'(idx - IDX_RESERVED_12);

    // The slave never inserts wait states, so read data must be ready at
    // the access phase; it is caught from the bank during the setup cycle.
    assign pready  = 1'b1;
    assign pslverr = psel && penable && err_q;
    assign wr_en   = psel && penable && pwrite && !err_q;

    // Bus answer flops, loaded in the setup cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            err_q  <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else if (psel && !penable)
        begin
            err_q  <= !hit;
            // Unmapped reads answer zero with an error.
            if (!hit)
                prdata <= 32'h0000_0000;
            else if (idx == IDX_FORCE_INJECT)
                prdata <= {24'h00_0000, inject_q, regs_q[slot][COUNT_MSB:0]};
            else
                prdata <= {24'h00_0000, regs_q[slot]};
        end
    end

    // Plain storage for every register; the inject bit lives apart.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            regs_q[0]  <= RST_RESERVED_12;
            regs_q[1]  <= RST_FORCE_INJECT;
            regs_q[2]  <= RST_SELF_TEST;
            regs_q[3]  <= RST_VOLTAGE_GAIN_DIVISOR;
            regs_q[4]  <= RST_RESERVED_16;
            regs_q[5]  <= RST_SENSOR_CONTROL_PRIMARY;
            regs_q[6]  <= RST_SENSOR_CONTROL_SECONDARY;
            regs_q[7]  <= RST_THRESH;
            regs_q[8]  <= RST_THRESH;
            regs_q[9]  <= RST_THRESH;
            regs_q[10] <= RST_CSI_ALARM_EN;
        end
        else if (wr_en)
        begin
            // Bit 7 of the injection register is never stored here.
            regs_q[slot] <= (idx == IDX_FORCE_INJECT) ? {1'b0, pwdata[COUNT_MSB:0]}
                                                      : pwdata[7:0];
        end
    end

    //--------------------------------------------------------------------------
    // Forced parity error injection
    //--------------------------------------------------------------------------
    localparam int S_INJ  = 1;
    localparam int S_ST   = 2;
    localparam int S_GAIN = 3;
    localparam int S_CT0  = 5;
    localparam int S_CT1  = 6;
    localparam int S_V0   = 7;
    localparam int S_V1   = 8;
    localparam int S_T    = 9;
    localparam int S_CSI  = 10;

    // Self-test entry is the rising edge of the local enable bit.
    assign entering = regs_q[S_ST][LOCAL_EN_BIT] && !local_prev_q;
    assign start    = (wr_en && (idx == IDX_FORCE_INJECT) && pwdata[INJECT_BIT])
                    || (entering && (regs_q[S_ST][ERR_FIELD_MSB:ERR_FIELD_LSB] != 4'h0));

    // Edge tracker for self-test entry.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            local_prev_q <= 1'b0;
        else
            local_prev_q <= regs_q[S_ST][LOCAL_EN_BIT];
    end

    // Countdown of errors; a write landing on the last cycle restarts it.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            remaining_q <= 7'h00;
        else if (start && wr_en && (idx == IDX_FORCE_INJECT))
            remaining_q <= pwdata[COUNT_MSB:0];
        else if (start)
            remaining_q <= regs_q[S_INJ][COUNT_MSB:0];
        else if (remaining_q != 7'h00)
            remaining_q <= remaining_q - 7'h01;
    end

    // One strobe per remaining error, one cycle each.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            strobe_q <= 1'b0;
        else
            strobe_q <= (remaining_q != 7'h00);
    end

    // The inject bit reads one while a write-started sequence runs; set beats clear.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            inject_q <= 1'b0;
        else if (start && wr_en && (idx == IDX_FORCE_INJECT))
            inject_q <= 1'b1;
        else if (remaining_q == 7'h00)
            inject_q <= 1'b0;
    end

    //--------------------------------------------------------------------------
    // Control outputs
    //--------------------------------------------------------------------------
    assign parity_error_strobe     = strobe_q;
    assign self_test_mode          = regs_q[S_ST][LOCAL_EN_BIT];
    assign remote_self_test_enable = regs_q[S_ST][REMOTE_EN_BIT];
    assign voltage_gain_divisor    = regs_q[S_GAIN][GAIN_MSB:0];
    assign gain_setting_enable     = regs_q[S_CT1][GAIN_EN_BIT];
    assign sensors_enabled         = regs_q[S_CT0][SENS_EN_MSB:SENS_EN_LSB] == SENS_ON;
    assign volt0_sense_enable      = regs_q[S_CT0][0];
    assign volt1_sense_enable      = regs_q[S_CT0][PIN_SEL_MSB];

    // Upper select bit alone picks the slow internal clock.
    always_comb
    begin
        if (regs_q[S_ST][CLK_SEL_MSB])
            self_test_clock_select = BSAC_CLK_INT_25MHZ;
        else if (regs_q[S_ST][CLK_SEL_LSB])
            self_test_clock_select = BSAC_CLK_INT_50MHZ;
        else
            self_test_clock_select = BSAC_CLK_EXTERNAL;
    end

    //--------------------------------------------------------------------------
    // Threshold alarms, compared on quantized codes
    //--------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            alarm_q <= '0;
        else
        begin
            alarm_q.volt0_high_alarm <= sensors_enabled && volt0_sense_enable
                && (sense_codes.volt0 > regs_q[S_V0][HI_MSB:HI_LSB]);
            alarm_q.volt0_low_alarm  <= sensors_enabled && volt0_sense_enable
                && (sense_codes.volt0 < regs_q[S_V0][LO_MSB:0]);
            alarm_q.volt1_high_alarm <= sensors_enabled && volt1_sense_enable
                && (sense_codes.volt1 > regs_q[S_V1][HI_MSB:HI_LSB]);
            alarm_q.volt1_low_alarm  <= sensors_enabled && volt1_sense_enable
                && (sense_codes.volt1 < regs_q[S_V1][LO_MSB:0]);
            alarm_q.temp_high_alarm  <= sensors_enabled
                && (sense_codes.temp > regs_q[S_T][HI_MSB:HI_LSB]);
            alarm_q.temp_low_alarm   <= sensors_enabled
                && (sense_codes.temp < regs_q[S_T][LO_MSB:0]);
        end
    end
    assign sensor_alarms = alarm_q;

    // CSI-2 alarms pass only while their enable is set.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            no_fv_alarm_q <= 1'b0;
            sync_alarm_q  <= 1'b0;
        end
        else
        begin
            no_fv_alarm_q <= missing_frame_valid_event && regs_q[S_CSI][NO_FV_BIT];
            sync_alarm_q  <= phy_sync_error_event && regs_q[S_CSI][SYNC_ERR_BIT];
        end
    end
    assign missing_frame_valid_alarm = no_fv_alarm_q;
    assign phy_sync_error_alarm      = sync_alarm_q;

    //--------------------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence inject_write_s;
        wr_en && (idx == IDX_FORCE_INJECT) && pwdata[INJECT_BIT] && (pwdata[6:0] == 7'h03);
    endsequence

    inject_three_a: assert property (inject_write_s |=> ##1 strobe_q [*3] ##1 !strobe_q)
        else $error("three programmed errors did not give three strobes");
    inject_sets_a: assert property (inject_write_s |=> inject_q)
        else $error("inject bit not set by write");
    inject_clears_a: assert property ((remaining_q == 7'h00) && !start |=> !inject_q)
        else $error("inject bit failed to clear");
    entry_start_a: assert property (entering && (regs_q[S_ST][7:4] != 4'h0)
        && !wr_en |=> remaining_q == $past(regs_q[S_INJ][6:0]))
        else $error("self-test entry did not load count");
    field_zero_a: assert property (entering && (regs_q[S_ST][7:4] == 4'h0) && !wr_en
        && (remaining_q == 7'h00) |=> remaining_q == 7'h00)
        else $error("injection started with forcing disabled");
    clock_sel_a: assert property (regs_q[S_ST][2] |-> self_test_clock_select == BSAC_CLK_INT_25MHZ)
        else $error("upper select bit did not pick 25 MHz");
    v0_high_a: assert property (sensors_enabled && volt0_sense_enable
        && (sense_codes.volt0 > regs_q[S_V0][6:4]) |=> sensor_alarms.volt0_high_alarm)
        else $error("pin 0 high alarm missed");
    temp_low_a: assert property (!sensors_enabled |=> !sensor_alarms.temp_low_alarm)
        else $error("temperature alarm raised while disabled");
    frame_alarm_a: assert property (!regs_q[S_CSI][5] |=> !missing_frame_valid_alarm)
        else $error("frame alarm passed while disabled");

endmodule
`default_nettype wire

// ---- verilog/bsac_pkg.sv ----
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package bsac_pkg;

    //--------------------------------------------------------------------------
    // Register indices; the byte address on the bus is four times the index.
    //--------------------------------------------------------------------------
    localparam logic [5:0] IDX_RESERVED_12   = 6'h12; // Spare storage.
    localparam logic [5:0] IDX_FORCE_INJECT  = 6'h13; // Parity error injection.
    localparam logic [5:0] IDX_SELF_TEST     = 6'h14; // Self-test control.
    localparam logic [5:0] IDX_VOLTAGE_GAIN_DIVISOR     = 6'h15; // Voltage sensor gain.
    localparam logic [5:0] IDX_RESERVED_16   = 6'h16; // Spare storage.
    localparam logic [5:0] IDX_SENSOR_CONTROL_PRIMARY  = 6'h17; // Sensor enables.
    localparam logic [5:0] IDX_SENSOR_CONTROL_SECONDARY  = 6'h18; // Gain enable.
    localparam logic [5:0] IDX_V0_THRESH     = 6'h19; // Pin 0 limits.
    localparam logic [5:0] IDX_V1_THRESH     = 6'h1A; // Pin 1 limits.
    localparam logic [5:0] IDX_T_THRESH      = 6'h1B; // Temperature limits.
    localparam logic [5:0] IDX_CSI_ALARM_EN  = 6'h1C; // CSI-2 alarm enables.
    localparam int         NUM_REGS          = 11;    // Registers in the bank.

    //--------------------------------------------------------------------------
    // Reset values, in index order from the first register.
    //--------------------------------------------------------------------------
    localparam logic [7:0] RST_RESERVED_12  = 8'h00;
    localparam logic [7:0] RST_FORCE_INJECT = 8'h00;
    localparam logic [7:0] RST_SELF_TEST    = 8'h00;
    localparam logic [7:0] RST_VOLTAGE_GAIN_DIVISOR    = 8'h20;
    localparam logic [7:0] RST_RESERVED_16  = 8'h18;
    localparam logic [7:0] RST_SENSOR_CONTROL_PRIMARY = 8'h3C;
    localparam logic [7:0] RST_SENSOR_CONTROL_SECONDARY = 8'h80;
    localparam logic [7:0] RST_THRESH       = 8'h62;
    localparam logic [7:0] RST_CSI_ALARM_EN = 8'h3F;

    //--------------------------------------------------------------------------
    // Field positions.
    //--------------------------------------------------------------------------
    localparam int INJECT_BIT      = 7; // Self-clearing inject bit.
    localparam int COUNT_MSB       = 6; // Injected error count, bits 6:0.
    localparam int ERR_FIELD_MSB   = 7; // Forced error enable field, 7:4.
    localparam int ERR_FIELD_LSB   = 4;
    localparam int LOCAL_EN_BIT    = 3; // Local self-test enable.
    localparam int CLK_SEL_MSB     = 2; // Self-test clock select, 2:1.
    localparam int CLK_SEL_LSB     = 1;
    localparam int REMOTE_EN_BIT   = 0; // Remote self-test enable.
    localparam int GAIN_MSB        = 6; // Gain divisor, bits 6:0.
    localparam int SENS_EN_MSB     = 3; // Sensor enable, bits 3:2.
    localparam int SENS_EN_LSB     = 2;
    localparam int PIN_SEL_MSB     = 1; // Voltage pin select, bits 1:0.
    localparam int GAIN_EN_BIT     = 7; // Gain setting enable.
    localparam int HI_MSB          = 6; // Upper limit, bits 6:4.
    localparam int HI_LSB          = 4;
    localparam int LO_MSB          = 2; // Lower limit, bits 2:0.
    localparam int NO_FV_BIT       = 5; // Missing frame-valid alarm enable.
    localparam int SYNC_ERR_BIT    = 4; // Phy sync error alarm enable.
    localparam logic [1:0] SENS_ON = 2'b11; // Both sensors enabled.

    // Self-test clock source choices.
    typedef enum logic [1:0] {
        BSAC_CLK_EXTERNAL,
        BSAC_CLK_INT_50MHZ,
        BSAC_CLK_INT_25MHZ
    } bsac_clk_sel_e;

    // Quantized sensor reading codes.
    typedef struct packed {
        logic [2:0] volt0;
        logic [2:0] volt1;
        logic [2:0] temp;
    } bsac_sense_s;

    // Threshold alarm levels.
    typedef struct packed {
        logic volt0_high_alarm;
        logic volt0_low_alarm;
        logic volt1_high_alarm;
        logic volt1_low_alarm;
        logic temp_high_alarm;
        logic temp_low_alarm;
    } bsac_alarm_s;

endpackage

// ---- tb/bsac_regs_test.sv ----
`timescale 1ns/1ps
`default_nettype none
// Compares a value seen at the ports with the model's value and counts it.
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin n_mismatch++; \
    $display("mismatch %s expected %h seen %h", nm, ex, gt); end end
module bsac_regs_test;
    import bsac_pkg::*;
    // ------------------------------
    // Signals and model state
    // ------------------------------
    localparam int TIME_LIMIT = 20000; // Cycles; the run needs about 1900.
    logic          pclk;               // Bus clock, 5 ns.
    logic          presetn;            // Asynchronous reset, active low.
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [7:0]    paddr;
    logic [31:0]   pwdata;
    logic          pready;
    logic          pslverr;
    logic [31:0]   prdata;
    bsac_sense_s   sense_codes;        // Quantized sensor readings.
    logic          fv_event;           // Raw missing frame-valid event.
    logic          sync_event;         // Raw phy sync error event.
    logic          strobe;
    logic          st_mode;
    logic          remote_en;
    bsac_clk_sel_e clk_sel;
    logic [6:0]    gain_div;
    logic          gain_en;
    logic          sens_en;
    logic          v0_en;
    logic          v1_en;
    bsac_alarm_s   alarms;
    logic          fv_alarm;
    logic          sync_alarm;
    logic [7:0]    m [8'h12:8'h1C];    // Register model, by index.
    int            n_mismatch;
    int            n_compared;
    int            n_strobe;           // Cycles with the parity strobe high.
    int            n_cycle;            // Cycles since time zero.

    bsac_regs dut
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .sense_codes(sense_codes),
        .missing_frame_valid_event(fv_event), .phy_sync_error_event(sync_event),
        .parity_error_strobe(strobe), .self_test_mode(st_mode),
        .remote_self_test_enable(remote_en), .self_test_clock_select(clk_sel),
        .voltage_gain_divisor(gain_div), .gain_setting_enable(gain_en),
        .sensors_enabled(sens_en), .volt0_sense_enable(v0_en),
        .volt1_sense_enable(v1_en), .sensor_alarms(alarms),
        .missing_frame_valid_alarm(fv_alarm), .phy_sync_error_alarm(sync_alarm)
    );

    // Free-running clock.
    always #2.5 pclk = ~pclk;

    // Counts injected errors; one strobe cycle stands for one error.
    always @(posedge pclk)
    begin
        if (strobe === 1'b1)
            n_strobe++;
    end

    // Cuts a hang short; a run that reaches the ceiling is a failure.
    always @(posedge pclk)
    begin
        n_cycle++;
        if (n_cycle == TIME_LIMIT)
        begin
            n_mismatch++;
            close_out();
        end
    end

    // ------------------------------
    // Tasks
    // ------------------------------
    // Prints the verdict and ends the run.
    task automatic close_out();
        if (n_mismatch == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Loads the documented reset values into the model.
    task automatic reset_model();
        m = '{8'h00, 8'h00, 8'h00, 8'h20, 8'h18, 8'h3C, 8'h80, 8'h62, 8'h62, 8'h62, 8'h3F};
    endtask

    // One APB transfer; the request holds until pready is seen high.
    // Only the bench ceiling ends a wait, so a slave that never answers fails.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] wd,
                       output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h00_0000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Writes a mapped register and mirrors it; the inject bit is never stored.
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        logic [31:0] rd;
        logic        er;
        apb(1'b1, {i[5:0], 2'b00}, d, rd, er);
        m[i] = (i == 8'h13) ? {1'b0, d[6:0]} : d;
    endtask

    // Reads a mapped register and compares the whole word with the model.
    task automatic rd_chk(input logic [7:0] i);
        logic [31:0] rd;
        logic        er;
        apb(1'b0, {i[5:0], 2'b00}, 8'h00, rd, er);
        `CHK("read_data", {24'h00_0000, m[i]}, rd)
        `CHK("read_error", 1'b0, er)
    endtask

    // Alarms expected from the model and the present sensor codes.
    function automatic logic [5:0] exp_alarms();
        logic s;
        s = (m['h17][3:2] == 2'b11);
        return {s & m['h17][0] & (sense_codes.volt0 > m['h19][6:4]),
                s & m['h17][0] & (sense_codes.volt0 < m['h19][2:0]),
                s & m['h17][1] & (sense_codes.volt1 > m['h1A][6:4]),
                s & m['h17][1] & (sense_codes.volt1 < m['h1A][2:0]),
                s & (sense_codes.temp > m['h1B][6:4]),
                s & (sense_codes.temp < m['h1B][2:0])};
    endfunction

    // Lets registered outputs settle, then checks every decoded output.
    task automatic chk_outs();
        logic [1:0] cs;
        repeat (3) @(negedge pclk);
        cs = m['h14][2:1];
        `CHK("self_test_mode", m['h14][3], st_mode)
        `CHK("remote_enable", m['h14][0], remote_en)
        `CHK("clock_select", (cs[1] ? 2'd2 : cs), 2'(clk_sel))
        `CHK("gain_divisor", m['h15][6:0], gain_div)
        `CHK("gain_enable", m['h18][7], gain_en)
        `CHK("sensors_enabled", (m['h17][3:2] == 2'b11), sens_en)
        `CHK("volt_pins", m['h17][1:0], {v1_en, v0_en})
        `CHK("sensor_alarms", exp_alarms(), 6'(alarms))
        `CHK("frame_alarm", m['h1C][5] & fv_event, fv_alarm)
        `CHK("sync_alarm", m['h1C][4] & sync_event, sync_alarm)
    endtask

    // ------------------------------
    // Main sequence
    // ------------------------------
    initial
    begin
        logic [7:0]  rw  [10];
        logic [7:0]  inj [5];
        logic [3:0]  fld [4];
        logic [31:0] rd;
        logic        er;
        logic [7:0]  idx;
        logic [7:0]  dat;
        rw  = '{8'h12, 8'h13, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C};
        // A count of three is included so that the three-strobe check is reached.
        inj = '{8'h80, 8'h81, 8'h83, 8'hFF, 8'h09};
        fld = '{4'h0, 4'h1, 4'h8, 4'hF};
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        sense_codes = '0;
        fv_event = 1'b0;
        sync_event = 1'b0;
        n_mismatch = 0;
        n_compared = 0;
        n_strobe = 0;
        n_cycle = 0;
        void'($urandom(32'hd328));
        reset_model();
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values of every register and of the decoded outputs.
        for (int i = 'h12; i <= 'h1C; i++)
            rd_chk(8'(i));
        chk_outs();
        // Unmapped and misaligned accesses are refused and change nothing.
        apb(1'b0, 8'h44, 8'h00, rd, er);
        `CHK("unmapped_error", 1'b1, er)
        `CHK("unmapped_data", 32'h0000_0000, rd)
        apb(1'b1, 8'h49, 8'hAA, rd, er);
        `CHK("misaligned_error", 1'b1, er)
        apb(1'b1, 8'h74, 8'hFF, rd, er);
        `CHK("beyond_error", 1'b1, er)
        rd_chk(8'h12);
        // Random contents with moving sensor codes and events; the sensors
        // are kept on in the first half so that the alarms get exercised.
        for (int k = 0; k < 80; k++)
        begin
            @(posedge pclk);
            sense_codes <= bsac_sense_s'(9'($urandom));
            fv_event    <= 1'($urandom);
            sync_event  <= 1'($urandom);
            idx = rw[k % 10];
            dat = 8'($urandom);
            if (idx == 8'h13)
                dat[7] = 1'b0;
            if (idx == 8'h17 && k < 40)
                dat[3:2] = 2'b11;
            wr(idx, dat);
            rd_chk(idx);
            chk_outs();
        end
        // Write-triggered injection, including count 0, the largest count
        // and a write that leaves the inject bit clear.
        foreach (inj[j])
        begin
            n_strobe = 0;
            wr(8'h13, inj[j]);
            repeat (140) @(posedge pclk);
            `CHK("strobe_count", (inj[j][7] ? int'(inj[j][6:0]) : 0), n_strobe)
            rd_chk(8'h13);
        end
        // Entry into self-test injects only while the enable field is non-zero.
        for (int j = 0; j < 4; j++)
        begin
            wr(8'h13, 8'h06);
            n_strobe = 0;
            wr(8'h14, {fld[j], 1'b1, 2'(j), 1'(j)});
            repeat (20) @(posedge pclk);
            `CHK("entry_strobes", ((fld[j] != 4'h0) ? 6 : 0), n_strobe)
            chk_outs();
            wr(8'h14, 8'h00);
        end
        // A reset in mid-sequence stops the injection and restores defaults.
        wr(8'h13, 8'hFF);
        repeat (10) @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        reset_model();
        n_strobe = 0;
        repeat (140) @(posedge pclk);
        `CHK("strobes_after_reset", 0, n_strobe)
        rd_chk(8'h13);
        chk_outs();
        close_out();
    end
endmodule
`default_nettype wire
